// ### src/spi_core_register_interface.sv
// register side of the spi core: holding words, flags, enables, selects
// assumes a word-addressed host bus on clock and a free-running link clock
//
// What this block does
// - Software sees 32-bit registers that a memory-mapped host reads and writes.
// - Word offsets: rx 0, tx 1, status 2, control 3, rsvd 4, mask 5, match 6.
// - Undefined bits read as anything; writes to them change nothing.
// - Bits above data width in data and match registers are undefined.
// - A fully received word loads rx holding and sets receive ready, bit 7.
// - Reading rx holding clears receive ready; writing it does nothing.
// - New words always load; if ready was set, receive overrun bit 3 sets.
// - Writing tx holding clears transmit ready bit 6; transfer out sets it.
// - Tx write while not ready sets overrun bit 4 and drops the word.
// - A status write clears both overruns and error unless a receive overrun sets that cycle; status reads change nothing.
// - Host mode: shift empty bit 5 low during transfer, high when empty.
// - Agent mode: shift empty low while selected or busy.
// - Error bit 8 is the OR of both overrun flags.
// - Packet end bit 9 sets when rx read or tx write matches match word.
// - Control holds enables at bits 3,4,6,7,8,9 and forced select at 10.
// - Select mask and forced select exist only in host mode.
// - Interrupt request rises when any flag and its enable are both 1.
// - After reset every control bit is 0.
// - After reset select mask is 1 in bit 0 only.
// - Select mask is applied at transfer start or forced select rising.
`timescale 1ns/1ps
`include "spi_cfg.svh"
module spi_core_register_interface
    import spi_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire logic [`ADDR_W-1:0] address,
    input  wire logic              chipselect,
    input  wire logic              read,
    input  wire logic              write,
    input  bus_word_t              writedata,
    output bus_word_t              readdata,
    output logic                   irq,
    input  wire logic              link_clock,
    input  wire logic              miso,
    output logic                   mosi,
    output logic                   sclk_enable,
    input  wire logic              agent_select_n,
    output agent_mask_t            ss_n
);
    logic        rd_strobe;
    logic        wr_strobe;
    logic        rd_rx;
    logic        wr_tx;
    logic        wr_status;
    logic        wr_control;
    logic        wr_mask;
    logic        wr_match;

    data_word_t  rx_holding_word;
    data_word_t  tx_holding_word;
    data_word_t  packet_end_match_word;
    bus_word_t   control_enables;
    agent_mask_t agent_select_mask;
    agent_mask_t applied_mask;

    logic        receive_ready_flag;
    logic        transmit_ready_flag;
    logic        receive_overrun_flag;
    logic        transmit_overrun_flag;
    logic        packet_end_flag;
    logic        shift_empty_flag;
    logic        error_flag;
    bus_word_t   status_flags;

    logic        busy;
    logic        launch;
    logic        start_toggle;
    data_word_t  tx_shift_word;
    logic        done_toggle;
    data_word_t  rx_link_word;
    logic        done_meta;
    logic        done_sync;
    logic        done_seen;
    logic        word_done;
    logic        sel_meta;
    logic        sel_sync;
    logic        forced_select_output;
    logic        forced_select_rise;
    bus_word_t   next_control;
    bus_word_t   ctrl_wmask;

    // bus decode, one access per strobe cycle
    assign rd_strobe  = chipselect && read;
    assign wr_strobe  = chipselect && write;
    assign rd_rx      = rd_strobe && address == `ADDR_RX;
    assign wr_tx      = wr_strobe && address == `ADDR_TX;
    assign wr_status  = wr_strobe && address == `ADDR_STATUS;
    assign wr_control = wr_strobe && address == `ADDR_CONTROL;
    assign wr_mask    = wr_strobe && address == `ADDR_MASK && `HOST_MODE;
    assign wr_match   = wr_strobe && address == `ADDR_EOPV;

    // crossings from the link domain
    always_ff @(posedge clock) begin
        if (srst) begin
            done_meta <= 1'b0;
            done_sync <= 1'b0;
            done_seen <= 1'b0;
            sel_meta  <= 1'b1;
            sel_sync  <= 1'b1;
        end else begin
            done_meta <= done_toggle;
            done_sync <= done_meta;
            done_seen <= done_sync;
            sel_meta  <= agent_select_n;
            sel_sync  <= sel_meta;
        end
    end

    assign word_done = done_sync ^ done_seen;

    // a pending tx word starts as soon as the link is idle
    assign launch = !busy && !transmit_ready_flag;

    always_ff @(posedge clock) begin
        if (srst) begin
            busy          <= 1'b0;
            start_toggle  <= 1'b0;
            tx_shift_word <= `DATA_ZERO;
        end else if (launch) begin
            busy          <= 1'b1;
            start_toggle  <= ~start_toggle;
            tx_shift_word <= tx_holding_word;
        end else if (word_done) begin
            busy          <= 1'b0;
        end
    end

    spi_link_shifter link_shifter (
        .link_clock   (link_clock),
        .srst         (srst),
        .start_toggle (start_toggle),
        .tx_word      (tx_shift_word),
        .miso         (miso),
        .done_toggle  (done_toggle),
        .rx_word      (rx_link_word),
        .mosi         (mosi),
        .sclk_enable  (sclk_enable)
    );

    // rx holding always takes the new word
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_holding_word <= `DATA_ZERO;
        end else if (word_done) begin
            rx_holding_word <= rx_link_word;
        end
    end

    // set wins over the read clear
    always_ff @(posedge clock) begin
        if (srst) begin
            receive_ready_flag <= 1'b0;
        end else if (word_done) begin
            receive_ready_flag <= 1'b1;
        end else if (rd_rx) begin
            receive_ready_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            receive_overrun_flag <= 1'b0;
        end else if (word_done && receive_ready_flag) begin
            receive_overrun_flag <= 1'b1;
        end else if (wr_status) begin
            receive_overrun_flag <= 1'b0;
        end
    end

    // tx write accepted only while ready, otherwise dropped
    always_ff @(posedge clock) begin
        if (srst) begin
            tx_holding_word <= `DATA_ZERO;
        end else if (wr_tx && transmit_ready_flag) begin
            tx_holding_word <= writedata[`DATA_WIDTH-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            transmit_ready_flag <= 1'b1;
        end else if (wr_tx && transmit_ready_flag) begin
            transmit_ready_flag <= 1'b0;
        end else if (launch) begin
            transmit_ready_flag <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            transmit_overrun_flag <= 1'b0;
        end else if (wr_tx && !transmit_ready_flag) begin
            transmit_overrun_flag <= 1'b1;
        end else if (wr_status) begin
            transmit_overrun_flag <= 1'b0;
        end
    end

    assign error_flag = receive_overrun_flag | transmit_overrun_flag;

    // packet end match on rx reads and accepted or refused tx writes
    always_ff @(posedge clock) begin
        if (srst) begin
            packet_end_flag <= 1'b0;
        end else if ((rd_rx && rx_holding_word == packet_end_match_word) ||
                     (wr_tx && writedata[`DATA_WIDTH-1:0] ==
                      packet_end_match_word)) begin
            packet_end_flag <= 1'b1;
        end else if (wr_status) begin
            packet_end_flag <= 1'b0;
        end
    end

    // host: empty when idle; agent: not empty while selected or busy
    assign shift_empty_flag = `HOST_MODE ? (!busy && transmit_ready_flag)
                                         : (sel_sync && !busy);

    always_comb begin
        status_flags                = `WORD_ZERO;
        status_flags[`ST_RX_OVERRUN]  = receive_overrun_flag;
        status_flags[`ST_TX_OVERRUN]  = transmit_overrun_flag;
        status_flags[`ST_SHIFT_EMPTY] = shift_empty_flag;
        status_flags[`ST_TX_READY]    = transmit_ready_flag;
        status_flags[`ST_RX_READY]    = receive_ready_flag;
        status_flags[`ST_ERR]       = error_flag;
        status_flags[`ST_EOP]       = packet_end_flag;
    end

    // only defined control bits take a write
    assign ctrl_wmask   = `HOST_MODE ? `CTRL_WMASK_HOST
                                     : `CTRL_WMASK_AGENT;
    assign next_control = (control_enables & ~ctrl_wmask) |
                          (writedata & ctrl_wmask);

    always_ff @(posedge clock) begin
        if (srst) begin
            control_enables <= `CTRL_RESET;
        end else if (wr_control) begin
            control_enables <= next_control;
        end
    end

    assign forced_select_output = control_enables[`CT_FORCED_SEL];
    assign forced_select_rise   = wr_control &&
                                  next_control[`CT_FORCED_SEL] &&
                                  !forced_select_output;

    always_ff @(posedge clock) begin
        if (srst) begin
            agent_select_mask <= `MASK_RESET;
        end else if (wr_mask) begin
            agent_select_mask <= writedata[`NUM_AGENTS-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            packet_end_match_word <= `DATA_ZERO;
        end else if (wr_match) begin
            packet_end_match_word <= writedata[`DATA_WIDTH-1:0];
        end
    end

    // mask is sampled only at launch or forced select rising
    always_ff @(posedge clock) begin
        if (srst) begin
            applied_mask <= `MASK_RESET;
        end else if (launch || forced_select_rise) begin
            applied_mask <= agent_select_mask;
        end
    end

    always_ff @(posedge clock) begin
        if (srst || !`HOST_MODE) begin
            ss_n <= '1;
        end else if (busy || forced_select_output) begin
            ss_n <= ~applied_mask;
        end else begin
            ss_n <= '1;
        end
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge clock) begin
        if (srst) begin
            readdata <= `WORD_ZERO;
        end else if (rd_strobe) begin
            unique case (address)
                `ADDR_RX:      readdata <= {{(`WORD_W-`DATA_WIDTH){1'b0}},
                                            rx_holding_word};
                `ADDR_STATUS:  readdata <= status_flags;
                `ADDR_CONTROL: readdata <= control_enables;
                `ADDR_MASK:    readdata <= {{(`WORD_W-`NUM_AGENTS){1'b0}},
                                            agent_select_mask};
                `ADDR_EOPV:    readdata <= {{(`WORD_W-`DATA_WIDTH){1'b0}},
                                            packet_end_match_word};
                default:       readdata <= `WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_flags[`IRQ_HI:`IRQ_LO] &
                     control_enables[`IRQ_HI:`IRQ_LO]);
        end
    end
endmodule

// ### src/spi_cfg.svh
// constants for the spi register interface: offsets, bit positions, resets
// assumes inclusion by bare name from the package and every design file
`ifndef SPI_CFG_SVH
`define SPI_CFG_SVH

`define WORD_W        32
`define DATA_WIDTH    8
`define NUM_AGENTS    8
`define BIT_CNT_W     4
`define HOST_MODE     1'b1

`define ADDR_W        3
`define ADDR_RX       3'h0
`define ADDR_TX       3'h1
`define ADDR_STATUS   3'h2
`define ADDR_CONTROL  3'h3
`define ADDR_RSVD     3'h4
`define ADDR_MASK     3'h5
`define ADDR_EOPV     3'h6

`define ST_RX_OVERRUN  3
`define ST_TX_OVERRUN  4
`define ST_SHIFT_EMPTY 5
`define ST_TX_READY    6
`define ST_RX_READY    7
`define ST_ERR         8
`define ST_EOP         9
`define CT_FORCED_SEL  10
`define IRQ_LO        3
`define IRQ_HI        9

`define CTRL_WMASK_HOST  32'h000007D8
`define CTRL_WMASK_AGENT 32'h000003D8
`define CTRL_RESET       32'h00000000
`define MASK_RESET       8'h01
`define WORD_ZERO        32'h00000000
`define DATA_ZERO        8'h00
`define CNT_ONE          4'h1
`define CNT_FULL         4'h8

`endif

// ### src/spi_pkg.sv
// types shared by the spi register interface and its link shifter
// assumes spi_cfg.svh is on the include path
`include "spi_cfg.svh"
package spi_pkg;
    typedef logic [`DATA_WIDTH-1:0] data_word_t;
    typedef logic [`WORD_W-1:0]     bus_word_t;
    typedef logic [`NUM_AGENTS-1:0] agent_mask_t;
    typedef logic [`BIT_CNT_W-1:0]  bit_count_t;
endpackage

// ### src/spi_link_shifter.sv
// link-side shift engine, clocked by the serial link clock
// assumes link_clock runs freely; tx_word holds steady from a start toggle
// until the matching done toggle comes back
`timescale 1ns/1ps
`include "spi_cfg.svh"
module spi_link_shifter
    import spi_pkg::*;
(
    input  wire logic       link_clock,
    input  wire logic       srst,
    input  wire logic       start_toggle,
    input  data_word_t      tx_word,
    input  wire logic       miso,
    output logic            done_toggle,
    output data_word_t      rx_word,
    output logic            mosi,
    output logic            sclk_enable
);
    logic       rst_meta;
    logic       link_rst;
    logic       start_meta;
    logic       start_sync;
    logic       start_seen;
    logic       start_edge;
    data_word_t shift_reg;
    bit_count_t bit_count;

    // reset carried into the link domain
    always_ff @(posedge link_clock) begin
        rst_meta <= srst;
        link_rst <= rst_meta;
    end

    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            start_meta <= 1'b0;
            start_sync <= 1'b0;
            start_seen <= 1'b0;
        end else begin
            start_meta <= start_toggle;
            start_sync <= start_meta;
            start_seen <= start_sync;
        end
    end

    assign start_edge = start_sync ^ start_seen;

    // msb first, one bit per link clock
    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            shift_reg   <= `DATA_ZERO;
            bit_count   <= '0;
            sclk_enable <= 1'b0;
        end else if (start_edge && !sclk_enable) begin
            shift_reg   <= tx_word;
            bit_count   <= `CNT_FULL;
            sclk_enable <= 1'b1;
        end else if (sclk_enable) begin
            shift_reg   <= {shift_reg[`DATA_WIDTH-2:0], miso};
            bit_count   <= bit_count - `CNT_ONE;
            if (bit_count == `CNT_ONE) begin
                sclk_enable <= 1'b0;
            end
        end
    end

    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            rx_word     <= `DATA_ZERO;
            done_toggle <= 1'b0;
        end else if (sclk_enable && bit_count == `CNT_ONE) begin
            rx_word     <= {shift_reg[`DATA_WIDTH-2:0], miso};
            done_toggle <= ~done_toggle;
        end
    end

    assign mosi = shift_reg[`DATA_WIDTH-1];
endmodule

// ### testbench/spi_core_register_interface_asserts.sv
// concurrent checks on the register interface ports, bound to the core
// assumes the host-mode build with an 8-bit data word
`timescale 1ns/1ps
`include "spi_cfg.svh"
module spi_core_register_interface_asserts
    import spi_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic [2:0]  address,
    input  wire logic        chipselect,
    input  wire logic        read,
    input  wire logic        write,
    input  bus_word_t        writedata,
    input  bus_word_t        readdata,
    input  wire logic        irq,
    input  wire logic        link_clock,
    input  wire logic        sclk_enable,
    input  agent_mask_t      ss_n
);
    // a write followed at once by a read of the same slot returns kept bits
    property p_readback(a, m);
        bus_word_t d;
        @(posedge clock) disable iff (srst)
        (chipselect && write && address == a, d = writedata)
        ##1 (chipselect && read && address == a) |=> readdata == (d & m);
    endproperty

    a_reset_quiet: assert property (
        @(posedge clock) srst |=>
        readdata == 32'h0 && irq == 1'b0 && ss_n == 8'hFF)
        else $error("outputs not quiet after reset");
    a_rsvd_reads_zero: assert property (
        @(posedge clock) disable iff (srst)
        chipselect && read && address == 3'h4 |=> readdata == 32'h0)
        else $error("reserved slot read not zero");
    a_readdata_holds: assert property (
        @(posedge clock) disable iff (srst)
        !(chipselect && read) |=> $stable(readdata))
        else $error("read data moved without a read");
    a_upper_bits_zero: assert property (
        @(posedge clock) disable iff (srst)
        chipselect && read && (address == 3'h0 || address == 3'h6)
        |=> readdata[31:8] == 24'h0)
        else $error("bits above the data word not zero");
    a_ctrl_readback: assert property (
        p_readback(3'h3, 32'h000007D8))
        else $error("control readback wrong");
    a_mask_readback: assert property (
        p_readback(3'h5, 32'h000000FF))
        else $error("select mask readback wrong");
    a_match_readback: assert property (
        p_readback(3'h6, 32'h000000FF))
        else $error("match word readback wrong");
    a_error_is_or: assert property (
        @(posedge clock) disable iff (srst)
        chipselect && read && address == 3'h2
        |=> readdata[8] == (readdata[3] | readdata[4]))
        else $error("error flag not the or of overruns");
    a_status_write_clears: assert property (
        @(posedge clock) disable iff (srst)
        chipselect && write && address == 3'h2
        ##1 chipselect && read && address == 3'h2 |=> readdata[4:3] == 2'b00)
        else $error("overrun flags survive a status write");
    a_rx_read_clears: assert property (
        @(posedge clock) disable iff (srst)
        chipselect && read && address == 3'h0
        ##3 chipselect && read && address == 3'h2 |=> !readdata[7])
        else $error("receive ready survives an rx read");
    a_shift_selects: assert property (
        @(posedge link_clock) disable iff (srst)
        sclk_enable |-> ss_n != 8'hFF)
        else $error("shifting with no agent selected");

    c_transfer: cover property (@(posedge link_clock) $rose(sclk_enable));
    c_irq: cover property (@(posedge clock) $rose(irq));
    c_overrun_seen: cover property (@(posedge clock)
        chipselect && read && address == 3'h2 ##1 readdata[4]);
endmodule

bind spi_core_register_interface spi_core_register_interface_asserts
    spi_core_register_interface_asserts_i (
    .clock(clock), .srst(srst), .address(address), .chipselect(chipselect),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .irq(irq), .link_clock(link_clock), .sclk_enable(sclk_enable),
    .ss_n(ss_n));

// ### testbench/spi_agent_model.sv
// behavioural spi agent: answers a byte msb first, records what it heard
// assumes the host samples miso on rising link edges while sclk is enabled
`timescale 1ns/1ps
module spi_agent_model (
    input  wire logic        link_clock,
    input  wire logic        sclk_enable,
    input  wire logic        mosi,
    input  wire logic        select_n,
    input  wire logic [7:0]  reply,
    output logic             miso,
    output logic [7:0]       heard
);
    logic [3:0] count;
    initial begin
        count = 4'h0;
        miso = 1'b0;
        heard = 8'h00;
    end
    // the bit counter restarts whenever the link clock is gated off
    always @(posedge link_clock) begin
        if (select_n || !sclk_enable) begin
            count <= 4'h0;
        end else if (sclk_enable) begin
            heard <= {heard[6:0], mosi};
            count <= count + 4'h1;
        end
    end
    // an unselected agent leaves the line wandering, not at a stable level
    always @(negedge link_clock) begin
        if (select_n) begin
            miso <= ~miso;
        end else if (count < 4'h8) begin
            miso <= reply[3'h7 - count[2:0]];
        end
    end
endmodule

// ### testbench/spi_core_register_interface_tb_top.sv
// self-checking bench for the register interface with an agent model
// assumes the host-mode build; agent 0 sits on the first select line
`timescale 1ns/1ps
module spi_core_register_interface_tb_top;
    import spi_pkg::*;
    logic        clock = 1'b0;
    logic        link_clock = 1'b0;
    logic        srst, chipselect, read, write, irq, miso, mosi, sclk_enable;
    logic [2:0]  address;
    bus_word_t   writedata, readdata, rdata;
    agent_mask_t ss_n;
    logic [7:0]  reply, heard;
    int          n_mismatch = 0;
    int          tests_run = 0;

    always #20 clock = ~clock;
    initial begin
        #7;
        forever #32 link_clock = ~link_clock;
    end

    spi_core_register_interface spi_core_register_interface_i (
        .clock(clock), .srst(srst), .address(address),
        .chipselect(chipselect), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .irq(irq),
        .link_clock(link_clock), .miso(miso), .mosi(mosi),
        .sclk_enable(sclk_enable), .agent_select_n(1'b1), .ss_n(ss_n));
    spi_agent_model spi_agent_model_i (
        .link_clock(link_clock), .sclk_enable(sclk_enable), .mosi(mosi),
        .select_n(ss_n[0]), .reply(reply), .miso(miso), .heard(heard));

    task automatic test_done;
        if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input bus_word_t exp,
                       input bus_word_t got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input bus_word_t d);
        address <= a;
        writedata <= d;
        chipselect <= 1'b1;
        write <= 1'b1;
        read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [2:0] a);
        address <= a;
        chipselect <= 1'b1;
        read <= 1'b1;
        write <= 1'b0;
        @(posedge clock);
        chipselect <= 1'b0;
        read <= 1'b0;
        @(posedge clock);
        @(negedge clock) rdata = readdata;
        @(posedge clock);
    endtask
    task automatic settle;
        chipselect <= 1'b0;
        write <= 1'b0;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic wait_flag(input int b, input logic v);
        int k;
        for (k = 0; k < 100; k++) begin
            rd(3'h2);
            if (rdata[b] === v) break;
        end
        if (k == 100) chk("status wait", 32'h1, 32'h0);
    endtask
    task automatic xfer(input logic [7:0] d, input logic [7:0] a);
        reply <= a;
        wr(3'h1, {24'h0, d});
        rd(3'h2);
        chk("busy flags", 32'h0, rdata & 32'h60);
        wait_flag(7, 1'b1);
        rd(3'h0);
        chk("rx word", {24'h0, a}, rdata);
        chk("agent heard", {24'h0, d}, {24'h0, heard});
        rd(3'h2);
        chk("receive ready after read", 32'h0, rdata & 32'h80);
        wait_flag(5, 1'b1);
    endtask

    initial begin
        repeat (30000) @(posedge clock);
        n_mismatch++;
        test_done;
    end

    initial begin
        logic [7:0] d1, d2, a1;
        srst = 1'b1;
        address = 3'h0;
        chipselect = 1'b0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        reply = 8'h00;
        d1 = 8'($urandom(32'h46DCA39A));
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        rd(3'h2);
        chk("status reset", 32'h60, rdata);
        rd(3'h3);
        chk("control reset", 32'h0, rdata);
        rd(3'h5);
        chk("mask reset", 32'h1, rdata);
        rd(3'h6);
        chk("match reset", 32'h0, rdata);
        rd(3'h4);
        chk("reserved", 32'h0, rdata);
        wr(3'h3, 32'hFFFFFFFF);
        rd(3'h3);
        chk("control kept", 32'h000007D8, rdata);
        wr(3'h3, 32'h40);
        settle;
        chk("irq on", 32'h1, {31'h0, irq});
        @(posedge clock);
        wr(3'h3, 32'h0);
        settle;
        chk("irq off", 32'h0, {31'h0, irq});
        @(posedge clock);
        wr(3'h0, 32'hA5);
        rd(3'h2);
        chk("rx write ignored", 32'h60, rdata);
        // packet end on a matching tx word, then cleared by a status write
        wr(3'h6, {24'h0, d1});
        rd(3'h6);
        chk("match word", {24'h0, d1}, rdata);
        xfer(d1, 8'($urandom()));
        rd(3'h2);
        chk("packet end", 32'h200, rdata & 32'h200);
        wr(3'h2, 32'h0);
        rd(3'h2);
        chk("status cleared", 32'h60, rdata);
        xfer(8'h00, 8'hFF);
        xfer(8'hFF, 8'h00);
        repeat (4) xfer(8'($urandom()), 8'($urandom()));
        // overrun on both sides: queued word, dropped word, unread rx word
        d1 = 8'($urandom());
        d2 = ~d1;
        a1 = 8'($urandom());
        reply <= a1;
        wr(3'h1, {24'h0, d1});
        settle;
        @(posedge clock);
        wr(3'h1, {24'h0, d2});
        wr(3'h1, 32'h5A);
        rd(3'h2);
        chk("tx overrun", 32'h110, rdata & 32'h110);
        wait_flag(3, 1'b1);
        wait_flag(5, 1'b1);
        chk("dropped word", {24'h0, d2}, {24'h0, heard});
        rd(3'h0);
        wr(3'h2, 32'h0);
        rd(3'h2);
        chk("errors cleared", 32'h0, rdata & 32'h118);
        // forced select takes the mask only on its rising edge
        wr(3'h5, 32'h24);
        rd(3'h5);
        chk("mask", 32'h24, rdata);
        wr(3'h3, 32'h400);
        settle;
        chk("forced select", 32'hDB, {24'h0, ss_n});
        @(posedge clock);
        wr(3'h5, 32'h81);
        settle;
        chk("mask held", 32'hDB, {24'h0, ss_n});
        @(posedge clock);
        wr(3'h3, 32'h0);
        settle;
        chk("select released", 32'hFF, {24'h0, ss_n});
        test_done;
    end
endmodule
